// File: sotc_pkg.sv
/*
 Package for the switch output time chain: register map, field positions,
 reset values, mode encodings and timebase constants.
 Assumes a 25 MHz system clock and a 32-bit APB register bus.
*/
package sotc_pkg;
   localparam int unsigned SYS_CLK_HZ   = 25_000_000;
   localparam int unsigned TICK_US      = 1000;
   localparam int unsigned TICK_CYCLES  = (SYS_CLK_HZ / 1_000_000) * TICK_US;
   localparam int          TW           = 16;
   localparam int          AW           = 8;

   // Register byte offsets
   localparam logic [AW-1:0] CTRL_OFS       = 8'h00;
   localparam logic [AW-1:0] CMD_OFS        = 8'h04;
   localparam logic [AW-1:0] STAIR_OFS      = 8'h08;
   localparam logic [AW-1:0] STAIR_MAX_OFS  = 8'h0c;
   localparam logic [AW-1:0] ON_DLY_OFS     = 8'h10;
   localparam logic [AW-1:0] OFF_DLY_OFS    = 8'h14;
   localparam logic [AW-1:0] FLASH_ON_OFS   = 8'h18;
   localparam logic [AW-1:0] FLASH_OFF_OFS  = 8'h1c;
   localparam logic [AW-1:0] PULSE_LIM_OFS  = 8'h20;
   localparam logic [AW-1:0] STATUS_OFS     = 8'h24;

   // CTRL fields
   localparam int CTRL_MODE_LSB   = 0;
   localparam int CTRL_TIME_DIS   = 2;
   localparam int CTRL_RETRIG_OFF = 3;
   localparam int CTRL_PUMP_EN    = 4;
   localparam int CTRL_L1_EN      = 5;
   localparam int CTRL_L1_FN_LSB  = 6;
   localparam int CTRL_L2_EN      = 8;
   localparam int CTRL_L2_FN_LSB  = 9;
   localparam int CTRL_FORCE_EN   = 11;
   localparam int CTRL_FORCE_VAL  = 12;
   localparam int CTRL_W          = 13;
   localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0004;

   // CMD write fields: one command per write, taken in arrival order
   localparam int CMD_SWITCH   = 0;
   localparam int CMD_L1       = 1;
   localparam int CMD_L2       = 2;
   localparam int CMD_TIME_DIS = 3;
   localparam int CMD_SEL_LSB  = 8;

   localparam logic [TW-1:0] STAIR_RST     = 16'h0bb8;
   localparam logic [TW-1:0] STAIR_MAX_RST = 16'h2ee0;
   localparam logic [TW-1:0] DLY_RST       = 16'h03e8;
   localparam logic [TW-1:0] FLASH_RST     = 16'h01f4;
   localparam logic [TW-1:0] PULSE_LIM_RST = 16'h0000;

   typedef enum logic [1:0] {
      MODE_STAIR = 2'h0,
      MODE_DELAY = 2'h1,
      MODE_FLASH = 2'h2,
      MODE_NONE  = 2'h3
   } sotc_mode_t;

   typedef enum logic [1:0] {
      LOGIC_AND  = 2'h0,
      LOGIC_OR   = 2'h1,
      LOGIC_XOR  = 2'h2,
      LOGIC_GATE = 2'h3
   } sotc_logic_t;

   typedef enum logic [1:0] {
      SEL_SWITCH = 2'h0,
      SEL_L1     = 2'h1,
      SEL_L2     = 2'h2,
      SEL_TDIS   = 2'h3
   } sotc_cmd_sel_t;
endpackage

// File: sotc_tick.sv
/*
 Millisecond timebase prescaler.
 Assumes the caller's clock enable freezes it along with the rest.
*/
`timescale 1ns/1ps
`default_nettype none
module sotc_tick #(
   parameter int unsigned DIV = sotc_pkg::TICK_CYCLES
) (
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic ce_in,
   output logic      tick_out
);
   localparam int CW = $clog2(DIV);
   logic [CW-1:0] cnt_reg;
   wire           wrap = (cnt_reg == CW'(DIV - 1));

   assign tick_out = ce_in & wrap;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_reg <= '0;
      end else if (ce_in) begin
         cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
      end
   end
endmodule
`default_nettype wire

// File: sotc_logic.sv
/*
 Two-stage logical connection of the switch command.
 Assumes values arrive as levels, a just-written one straight from the bus; pure combinational.
*/
`timescale 1ns/1ps
`default_nettype none
module sotc_logic (
   input  wire logic       sw_in,
   input  wire logic       l1_en_in,
   input  wire logic [1:0] l1_fn_in,
   input  wire logic       l1_val_in,
   input  wire logic       l2_en_in,
   input  wire logic [1:0] l2_fn_in,
   input  wire logic       l2_val_in,
   output logic            res_out,
   output logic            pass_out
);
   function automatic logic comb(input logic a, input logic b, input logic [1:0] fn);
      unique case (sotc_pkg::sotc_logic_t'(fn))
         sotc_pkg::LOGIC_AND: comb = a & b;
         sotc_pkg::LOGIC_OR:  comb = a | b;
         sotc_pkg::LOGIC_XOR: comb = a ^ b;
         sotc_pkg::LOGIC_GATE: comb = a;
      endcase
   endfunction

   wire gate1 = l1_en_in && (l1_fn_in == 2'h3) && !l1_val_in;
   wire gate2 = l2_en_in && (l2_fn_in == 2'h3) && !l2_val_in;
   wire mid   = l1_en_in ? comb(sw_in, l1_val_in, l1_fn_in) : sw_in;

   // Link 1 first, then link 2
   assign res_out  = l2_en_in ? comb(mid, l2_val_in, l2_fn_in) : mid;
   // A closed gate drops the telegram rather than storing it
   assign pass_out = !gate1 && !gate2;
endmodule
`default_nettype wire

// File: sotc_top.sv
/*
 Switch output time chain for one relay output: APB registers, logical
 connection, time stage (staircase, delays, flashing), forced operation
 and bus-voltage gating of the relay drive.
 Assumes BUS_OK_IN and APB come from logic on SYS_CLK_IN; BUS_OK_IN is
 treated as a pin and synchronised anyway.
*/
`timescale 1ns/1ps
`default_nettype none
module sotc_top #(
   parameter int unsigned TICK_DIV = sotc_pkg::TICK_CYCLES
) (
   input  wire logic        SYS_CLK_IN,
   input  wire logic        RST_IN,
   input  wire logic        CE_IN,
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [7:0]  PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   output logic      [31:0] PRDATA_OUT,
   output logic             PREADY_OUT,
   output logic             PSLVERR_OUT,
   input  wire logic        BUS_OK_IN,
   output logic             RELAY_OUT
);
   localparam int TW = sotc_pkg::TW;

   typedef enum logic [2:0] {
      ST_IDLE, ST_STAIR, ST_ON_DLY, ST_OFF_DLY, ST_FL_ON, ST_FL_OFF
   } sotc_state_t;

   // Registers
   logic [sotc_pkg::CTRL_W-1:0] ctrl_reg;
   logic [TW-1:0]   stair_reg, stair_max_reg, on_dly_reg, off_dly_reg;
   logic [TW-1:0]   fl_on_reg, fl_off_reg, pulse_lim_reg;
   logic            l1_val_reg, l2_val_reg, sw_val_reg;
   logic            bus_s1_reg, bus_s2_reg;
   logic            time_out_reg, relay_reg;
   logic [TW-1:0]   cnt_reg, cnt_next;
   logic [TW-1:0]   pulses_reg, pulses_next;
   logic            time_out_next;
   sotc_state_t     state_reg, state_next;
   logic [31:0]     rdata_reg;

   // Bus decode
   wire        acc      = PSEL_IN & PENABLE_IN & CE_IN;
   wire        wr       = acc & PWRITE_IN;
   // Loaded in setup so read data stands through the access phase
   wire        rd       = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN & CE_IN;
   wire [7:0]  a        = PADDR_IN;
   wire        hit      = (a == sotc_pkg::CTRL_OFS) | (a == sotc_pkg::CMD_OFS)
                        | (a == sotc_pkg::STAIR_OFS) | (a == sotc_pkg::STAIR_MAX_OFS)
                        | (a == sotc_pkg::ON_DLY_OFS) | (a == sotc_pkg::OFF_DLY_OFS)
                        | (a == sotc_pkg::FLASH_ON_OFS) | (a == sotc_pkg::FLASH_OFF_OFS)
                        | (a == sotc_pkg::PULSE_LIM_OFS) | (a == sotc_pkg::STATUS_OFS);
   wire        cmd_wr   = wr & (a == sotc_pkg::CMD_OFS);
   wire [1:0]  cmd_sel  = PWDATA_IN[sotc_pkg::CMD_SEL_LSB +: 2];
   wire        cmd_bit  = PWDATA_IN[sotc_pkg::CMD_SWITCH];

   assign PREADY_OUT  = 1'b1;
   assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~hit;
   assign PRDATA_OUT  = rdata_reg;

   // Control fields
   wire [1:0] mode      = ctrl_reg[sotc_pkg::CTRL_MODE_LSB +: 2];
   wire       time_dis  = ctrl_reg[sotc_pkg::CTRL_TIME_DIS];
   wire       no_retrig = ctrl_reg[sotc_pkg::CTRL_RETRIG_OFF];
   wire       pump_en   = ctrl_reg[sotc_pkg::CTRL_PUMP_EN];
   wire       force_en  = ctrl_reg[sotc_pkg::CTRL_FORCE_EN];
   wire       force_val = ctrl_reg[sotc_pkg::CTRL_FORCE_VAL];

   // Timebase and logic stage
   logic tick;
   logic link_res;
   logic link_pass;

   sotc_tick #(
      .DIV      (TICK_DIV)
   ) u_tick (
      .clk_in   (SYS_CLK_IN),
      .rst_in   (RST_IN),
      .ce_in    (CE_IN),
      .tick_out (tick)
   );

   // Logic stage sees the value just written so the recalc is same-cycle
   wire sw_now = (cmd_wr && cmd_sel == 2'h0) ? cmd_bit : sw_val_reg;
   wire l1_now = (cmd_wr && cmd_sel == 2'h1) ? PWDATA_IN[sotc_pkg::CMD_L1] : l1_val_reg;
   wire l2_now = (cmd_wr && cmd_sel == 2'h2) ? PWDATA_IN[sotc_pkg::CMD_L2] : l2_val_reg;

   sotc_logic u_logic (
      .sw_in     (sw_now),
      .l1_en_in  (ctrl_reg[sotc_pkg::CTRL_L1_EN]),
      .l1_fn_in  (ctrl_reg[sotc_pkg::CTRL_L1_FN_LSB +: 2]),
      .l1_val_in (l1_now),
      .l2_en_in  (ctrl_reg[sotc_pkg::CTRL_L2_EN]),
      .l2_fn_in  (ctrl_reg[sotc_pkg::CTRL_L2_FN_LSB +: 2]),
      .l2_val_in (l2_now),
      .res_out   (link_res),
      .pass_out  (link_pass)
   );

   // One APB write is one command, so arrival order is kept by the bus
   wire sw_event = cmd_wr & (cmd_sel == 2'h0) & link_pass;
   wire cmd_val  = link_res;
   wire on_cmd   = sw_event & cmd_val;
   wire off_cmd  = sw_event & ~cmd_val;

   // Pump-up sum, saturated at the maximum
   wire [TW:0]   pump_sum = {1'b0, cnt_reg} + {1'b0, stair_reg};
   wire [TW-1:0] pump_cap = (pump_sum > {1'b0, stair_max_reg}) ? stair_max_reg
                                                                : pump_sum[TW-1:0];
   wire          cnt_done = (cnt_reg <= 16'h0001);
   wire          lim_hit  = (pulse_lim_reg != 16'h0000) && (pulses_reg + 16'h0001 >= pulse_lim_reg);

   // Time stage
   always_comb begin
      state_next    = state_reg;
      cnt_next      = cnt_reg;
      pulses_next   = pulses_reg;
      time_out_next = time_out_reg;
      if (time_dis || mode == 2'h3) begin
         state_next = ST_IDLE;
         cnt_next   = '0;
         if (sw_event) begin
            time_out_next = cmd_val;
         end
      end else if (sw_event) begin
         unique case (sotc_pkg::sotc_mode_t'(mode))
            sotc_pkg::MODE_STAIR: begin
               if (on_cmd) begin
                  time_out_next = 1'b1;
                  state_next    = ST_STAIR;
                  if (state_reg != ST_STAIR) begin
                     cnt_next = stair_reg;
                  end else if (pump_en) begin
                     cnt_next = pump_cap;
                  end else if (!no_retrig) begin
                     cnt_next = stair_reg;
                  end
               end else begin
                  time_out_next = 1'b0;
                  state_next    = ST_IDLE;
                  cnt_next      = '0;
               end
            end
            sotc_pkg::MODE_DELAY: begin
               if (on_cmd) begin
                  state_next = ST_ON_DLY;
                  cnt_next   = on_dly_reg;
               end else begin
                  state_next = ST_OFF_DLY;
                  cnt_next   = off_dly_reg;
               end
            end
            sotc_pkg::MODE_FLASH: begin
               pulses_next = '0;
               if (on_cmd) begin
                  state_next    = ST_FL_ON;
                  time_out_next = 1'b1;
                  cnt_next      = fl_on_reg;
               end else begin
                  state_next    = ST_IDLE;
                  time_out_next = 1'b0;
                  cnt_next      = '0;
               end
            end
            default: begin
               state_next = ST_IDLE;
            end
         endcase
      end else if (tick && state_reg != ST_IDLE) begin
         if (!cnt_done) begin
            cnt_next = cnt_reg - 16'h0001;
         end else begin
            unique case (state_reg)
               ST_STAIR: begin
                  time_out_next = 1'b0;
                  state_next    = ST_IDLE;
                  cnt_next      = '0;
               end
               ST_ON_DLY, ST_OFF_DLY: begin
                  time_out_next = (state_reg == ST_ON_DLY);
                  state_next    = ST_IDLE;
                  cnt_next      = '0;
               end
               ST_FL_ON: begin
                  time_out_next = 1'b0;
                  cnt_next      = fl_off_reg;
                  if (lim_hit) begin
                     state_next = ST_IDLE;
                     cnt_next   = '0;
                  end else begin
                     state_next  = ST_FL_OFF;
                     pulses_next = pulses_reg + 16'h0001;
                  end
               end
               ST_FL_OFF: begin
                  time_out_next = 1'b1;
                  state_next    = ST_FL_ON;
                  cnt_next      = fl_on_reg;
               end
               default: begin
                  state_next = ST_IDLE;
               end
            endcase
         end
      end
   end

   // Forced operation, then bus voltage
   wire final_val = force_en ? force_val : time_out_reg;
   wire relay_go  = bus_s2_reg & (final_val != relay_reg);

   // Register read mux
   logic [31:0] rmux;
   always_comb begin
      rmux = 32'h0000_0000;
      unique case (a)
         sotc_pkg::CTRL_OFS:      rmux[sotc_pkg::CTRL_W-1:0] = ctrl_reg;
         sotc_pkg::CMD_OFS:       rmux[3:0] = {time_dis, l2_val_reg, l1_val_reg, sw_val_reg};
         sotc_pkg::STAIR_OFS:     rmux[TW-1:0] = stair_reg;
         sotc_pkg::STAIR_MAX_OFS: rmux[TW-1:0] = stair_max_reg;
         sotc_pkg::ON_DLY_OFS:    rmux[TW-1:0] = on_dly_reg;
         sotc_pkg::OFF_DLY_OFS:   rmux[TW-1:0] = off_dly_reg;
         sotc_pkg::FLASH_ON_OFS:  rmux[TW-1:0] = fl_on_reg;
         sotc_pkg::FLASH_OFF_OFS: rmux[TW-1:0] = fl_off_reg;
         sotc_pkg::PULSE_LIM_OFS: rmux[TW-1:0] = pulse_lim_reg;
         sotc_pkg::STATUS_OFS:    rmux = {cnt_reg, 8'h00, 1'b0, state_reg,
                                          bus_s2_reg, final_val, time_out_reg, relay_reg};
         default:                 rmux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         bus_s1_reg <= 1'b0;
         bus_s2_reg <= 1'b0;
      end else if (CE_IN) begin
         bus_s1_reg <= BUS_OK_IN;
         bus_s2_reg <= bus_s1_reg;
      end
   end

   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         ctrl_reg      <= sotc_pkg::CTRL_RST;
         stair_reg     <= sotc_pkg::STAIR_RST;
         stair_max_reg <= sotc_pkg::STAIR_MAX_RST;
         on_dly_reg    <= sotc_pkg::DLY_RST;
         off_dly_reg   <= sotc_pkg::DLY_RST;
         fl_on_reg     <= sotc_pkg::FLASH_RST;
         fl_off_reg    <= sotc_pkg::FLASH_RST;
         pulse_lim_reg <= sotc_pkg::PULSE_LIM_RST;
         sw_val_reg    <= 1'b0;
         l1_val_reg    <= 1'b0;
         l2_val_reg    <= 1'b0;
         rdata_reg     <= 32'h0000_0000;
      end else if (CE_IN) begin
         if (rd) begin
            rdata_reg <= rmux;
         end
         if (wr) begin
            unique case (a)
               sotc_pkg::CTRL_OFS:      ctrl_reg <= PWDATA_IN[sotc_pkg::CTRL_W-1:0];
               sotc_pkg::STAIR_OFS:     stair_reg <= PWDATA_IN[TW-1:0];
               sotc_pkg::STAIR_MAX_OFS: stair_max_reg <= PWDATA_IN[TW-1:0];
               sotc_pkg::ON_DLY_OFS:    on_dly_reg <= PWDATA_IN[TW-1:0];
               sotc_pkg::OFF_DLY_OFS:   off_dly_reg <= PWDATA_IN[TW-1:0];
               sotc_pkg::FLASH_ON_OFS:  fl_on_reg <= PWDATA_IN[TW-1:0];
               sotc_pkg::FLASH_OFF_OFS: fl_off_reg <= PWDATA_IN[TW-1:0];
               sotc_pkg::PULSE_LIM_OFS: pulse_lim_reg <= PWDATA_IN[TW-1:0];
               sotc_pkg::CMD_OFS: begin
                  unique case (sotc_pkg::sotc_cmd_sel_t'(cmd_sel))
                     sotc_pkg::SEL_SWITCH: begin
                        // Blocked telegram is not stored
                        if (link_pass) begin
                           sw_val_reg <= cmd_bit;
                        end
                     end
                     sotc_pkg::SEL_L1: l1_val_reg <= PWDATA_IN[sotc_pkg::CMD_L1];
                     sotc_pkg::SEL_L2: l2_val_reg <= PWDATA_IN[sotc_pkg::CMD_L2];
                     sotc_pkg::SEL_TDIS: begin
                        ctrl_reg[sotc_pkg::CTRL_TIME_DIS] <= PWDATA_IN[sotc_pkg::CMD_TIME_DIS];
                     end
                  endcase
               end
               default: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         state_reg    <= ST_IDLE;
         cnt_reg      <= '0;
         pulses_reg   <= '0;
         time_out_reg <= 1'b0;
         relay_reg    <= 1'b0;
      end else if (CE_IN) begin
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         pulses_reg   <= pulses_next;
         time_out_reg <= time_out_next;
         if (relay_go) begin
            relay_reg <= final_val;
         end
      end
   end

   assign RELAY_OUT = relay_reg;
endmodule
`default_nettype wire

// File: sotc_chk.sv
/* Port checker for sotc_top, bound to every instance.
   Assumes one clock domain; CTRL and time-disable are shadowed from APB writes. */
`timescale 1ns/1ps
`default_nettype none
module sotc_chk (
   input wire logic        SYS_CLK_IN,
   input wire logic        RST_IN,
   input wire logic        CE_IN,
   input wire logic        PSEL_IN,
   input wire logic        PENABLE_IN,
   input wire logic        PWRITE_IN,
   input wire logic [7:0]  PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   input wire logic [31:0] PRDATA_OUT,
   input wire logic        PREADY_OUT,
   input wire logic        PSLVERR_OUT,
   input wire logic        BUS_OK_IN,
   input wire logic        RELAY_OUT
);
   default clocking @(posedge SYS_CLK_IN);
   endclocking
   default disable iff (RST_IN);
   logic [12:0] ctl_reg;
   logic        tdis_reg;
   wire         acc = PSEL_IN && PENABLE_IN && CE_IN;
   wire         bad = PADDR_IN > 8'h24 || PADDR_IN[1:0] != 2'h0;
   wire         wr  = acc && PWRITE_IN && !bad;
   wire         cmd = wr && PADDR_IN == 8'h04;
   wire         byp = (tdis_reg || ctl_reg[1:0] == 2'h3) && !ctl_reg[11] && !ctl_reg[5]
                      && !ctl_reg[8] && BUS_OK_IN;
   wire         sw_wr = cmd && PWDATA_IN[9:8] == 2'h0 && byp;
   wire         f_wr  = wr && PADDR_IN == 8'h00 && PWDATA_IN[11] && BUS_OK_IN;
   // Time-disable arrives as a register bit or as a telegram
   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         ctl_reg <= 13'h0004;
         tdis_reg <= 1'b1;
      end else if (wr && PADDR_IN == 8'h00) begin
         ctl_reg <= PWDATA_IN[12:0];
         tdis_reg <= PWDATA_IN[2];
      end else if (cmd && PWDATA_IN[9:8] == 2'h3) begin
         tdis_reg <= PWDATA_IN[3];
      end
   end
   a_ready_high: assert property (PREADY_OUT)
      else $error("pready low");
   a_slverr_map: assert property (acc |-> PSLVERR_OUT == bad)
      else $error("pslverr wrong");
   a_rd_unmapped: assert property (acc && !PWRITE_IN && bad |-> PRDATA_OUT == 32'h0)
      else $error("unmapped read not zero");
   a_bus_hold: assert property (!BUS_OK_IN [*4] |=> $stable(RELAY_OUT))
      else $error("relay moved without bus voltage");
   a_ce_freeze: assert property (!CE_IN [*2] |=> $stable(RELAY_OUT))
      else $error("relay moved while frozen");
   a_pass_on: assert property (sw_wr && PWDATA_IN[0] |-> ##[1:4] RELAY_OUT)
      else $error("bypass on late");
   a_pass_off: assert property (sw_wr && !PWDATA_IN[0] |-> ##[1:4] !RELAY_OUT)
      else $error("bypass off late");
   a_force_on: assert property (f_wr && PWDATA_IN[12] |-> ##[1:4] RELAY_OUT)
      else $error("forced on ignored");
   a_force_off: assert property (f_wr && !PWDATA_IN[12] |-> ##[1:4] !RELAY_OUT)
      else $error("forced off ignored");
   c_stair_end: cover property (!byp && $fell(RELAY_OUT));
   c_force: cover property (f_wr);
   c_bad: cover property (acc && bad);
endmodule
bind sotc_top sotc_chk sotc_chk_inst (.SYS_CLK_IN, .RST_IN, .CE_IN, .PSEL_IN, .PENABLE_IN,
   .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .BUS_OK_IN,
   .RELAY_OUT);
`default_nettype wire

// File: sotc_relay_model.sv
/* Bus supply and relay coil model: counts closures and on-time in clocks.
   Assumes the bench asks for bus voltage loss through bus_up_in. */
`timescale 1ns/1ps
`default_nettype none
module sotc_relay_model (
   input  wire logic  clk_in,
   input  wire logic  rst_in,
   input  wire logic  bus_up_in,
   input  wire logic  relay_in,
   output logic       bus_ok_out,
   output logic [7:0] ops_out,
   output logic [15:0] on_len_out
);
   logic [15:0] run_reg;
   logic        last_reg;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ops_out <= 8'h00;
         on_len_out <= 16'h0000;
         run_reg <= 16'h0000;
         last_reg <= 1'b0;
      end else begin
         last_reg <= relay_in;
         run_reg <= relay_in ? run_reg + 16'h0001 : 16'h0000;
         if (relay_in && !last_reg)
            ops_out <= ops_out + 8'h01;
         if (!relay_in && last_reg)
            on_len_out <= run_reg;
      end
   end
   // Supply level is not cleared by the logic reset
   always_ff @(posedge clk_in) begin
      bus_ok_out <= bus_up_in;
   end
endmodule
`default_nettype wire

// File: switch_output_time_chain_tb.sv
/* Self-checking bench for sotc_top: APB tasks and telegram scenarios.
   Assumes TICK_DIV of 4, so N ticks last 4*(N-1) to 4*N clocks. */
`timescale 1ns/1ps
`default_nettype none
module switch_output_time_chain_tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        ce = 1'b1;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [7:0]  pa = 8'h00;
   logic [31:0] pwd = 32'h0;
   logic [31:0] prd;
   logic        prdy;
   logic        perr;
   logic        err;
   logic        bus_up = 1'b1;
   logic        bus_ok;
   logic        relay;
   logic [7:0]  ops;
   logic [7:0]  o;
   logic [15:0] len;
   int          failures = 0;
   int          num_checks = 0;
   int          n;
   logic [7:0]  ra [9] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h28};
   logic [15:0] rv [9] = '{16'h4, 16'hbb8, 16'h2ee0, 16'h3e8, 16'h3e8, 16'h1f4, 16'h1f4,
                           16'h0, 16'h0};
   logic [15:0] wv [7] = '{16'h0, 16'ha, 16'h19, 16'h5, 16'h5, 16'h3, 16'h3};
   logic [3:0]  lv [4] = '{4'b1000, 4'b1101, 4'b0111, 4'b0100};
   always #20 clk = ~clk;
   sotc_top #(.TICK_DIV(4)) sotc_top_inst (.SYS_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce),
      .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd),
      .PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .BUS_OK_IN(bus_ok),
      .RELAY_OUT(relay));
   sotc_relay_model sotc_relay_model_inst (.clk_in(clk), .rst_in(rst), .bus_up_in(bus_up),
      .relay_in(relay), .bus_ok_out(bus_ok), .ops_out(ops), .on_len_out(len));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (prdy !== 1'b1);
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // Read data is taken at the edge that ends the access
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 32'h0);
      chk(prd, exp);
   endtask
   task automatic sw(input logic v);
      apb(8'h04, 1'b1, {31'h0, v});
   endtask
   task automatic swc(input logic v, input logic e);
      sw(v);
      repeat (3) @(posedge clk);
      chk(relay, e);
   endtask
   task automatic wait_rel(input logic v);
      n = 0;
      while (relay !== v && n < 800) begin
         @(posedge clk);
         n++;
      end
      if (n >= 800)
         chk(relay, v);
   endtask
   // One extra clock lets the model latch the finished on-time
   task automatic on_time(input int lo, input int hi);
      wait_rel(1'b1);
      wait_rel(1'b0);
      @(posedge clk);
      chk({31'h0, len >= lo && len <= hi}, 32'h1);
   endtask
   task automatic complete_run;
      if (failures == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      #1000000;
      failures++;
      $display("BAD %0t timeout", $time);
      complete_run();
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 9; i++)
         rd(ra[i], {16'h0, rv[i]});
      for (int i = 1; i < 7; i++)
         apb(ra[i], 1'b1, {16'h0, wv[i]});
      apb(8'h2c, 1'b1, 32'hffff);
      chk({31'h0, err}, 32'h1);
      ce <= 1'b0;
      apb(8'h08, 1'b1, 32'h4d);
      ce <= 1'b1;
      rd(8'h08, 32'ha);
      swc(1'b1, 1'b1);
      swc(1'b0, 1'b0);
      apb(8'h04, 1'b1, 32'h300);
      sw(1'b1);
      on_time(36, 44);
      for (int i = 0; i < 2; i++) begin
         apb(8'h00, 1'b1, i ? 32'h8 : 32'h0);
         sw(1'b1);
         repeat (20) @(posedge clk);
         sw(1'b1);
         on_time(i ? 36 : 56, i ? 46 : 72);
      end
      apb(8'h00, 1'b1, 32'h10);
      sw(1'b1);
      sw(1'b1);
      sw(1'b1);
      on_time(96, 112);
      apb(8'h00, 1'b1, 32'h1);
      sw(1'b1);
      repeat (8) @(posedge clk);
      chk(relay, 1'b0);
      wait_rel(1'b1);
      chk(relay, 1'b1);
      for (int i = 0; i < 2; i++) begin
         sw(i[0]);
         repeat (12) @(posedge clk);
         sw(i[0]);
         repeat (12) @(posedge clk);
         chk(relay, !i[0]);
         wait_rel(i[0]);
         chk(relay, i[0]);
      end
      sw(1'b0);
      wait_rel(1'b0);
      o = ops;
      sw(1'b1);
      repeat (8) @(posedge clk);
      sw(1'b0);
      repeat (40) @(posedge clk);
      chk(ops, o);
      apb(8'h20, 1'b1, 32'h2);
      apb(8'h00, 1'b1, 32'h2);
      o = ops;
      swc(1'b1, 1'b1);
      repeat (100) @(posedge clk);
      chk(ops - o, 32'h2);
      chk(relay, 1'b0);
      apb(8'h20, 1'b1, 32'h0);
      o = ops;
      sw(1'b1);
      repeat (100) @(posedge clk);
      swc(1'b0, 1'b0);
      chk({31'h0, ops - o >= 4}, 32'h1);
      apb(8'h00, 1'b1, 32'h167);
      for (int i = 0; i < 4; i++) begin
         apb(8'h04, 1'b1, {22'h0, 2'h1, 6'h0, lv[i][3], 1'b0});
         apb(8'h04, 1'b1, {22'h0, 2'h2, 5'h0, lv[i][2], 2'h0});
         swc(lv[i][1], lv[i][0]);
      end
      // Closed gate drops the telegram; once reopened, the next telegram passes
      apb(8'h00, 1'b1, 32'he7);
      apb(8'h04, 1'b1, 32'h100);
      swc(1'b1, 1'b0);
      apb(8'h04, 1'b1, 32'h102);
      swc(1'b1, 1'b1);
      apb(8'h00, 1'b1, 32'h507);
      swc(1'b1, 1'b0);
      apb(8'h00, 1'b1, 32'h1807);
      repeat (4) @(posedge clk);
      chk(relay, 1'b1);
      bus_up <= 1'b0;
      repeat (6) @(posedge clk);
      apb(8'h00, 1'b1, 32'h0807);
      repeat (20) @(posedge clk);
      chk(relay, 1'b1);
      bus_up <= 1'b1;
      repeat (8) @(posedge clk);
      chk(relay, 1'b0);
      apb(8'h00, 1'b1, 32'h1807);
      apb(8'h00, 1'b1, 32'h0807);
      repeat (4) @(posedge clk);
      chk(relay, 1'b0);
      complete_run();
   end
endmodule
`default_nettype wire
